//--- ibtq_consts.vh
// constants for the image block transfer queue
`ifndef IBTQ_CONSTS_VH
`define IBTQ_CONSTS_VH
// register byte offsets
`define IBTQ_OFS_CONTROL 8'h00
`define IBTQ_OFS_BLOCKS 8'h04
`define IBTQ_OFS_COMMAND 8'h08
`define IBTQ_OFS_CAPACITY 8'h0c
`define IBTQ_OFS_OCCUPANCY 8'h10
`define IBTQ_OFS_DROPS 8'h14
`define IBTQ_OFS_IRQ_STATUS 8'h18
`define IBTQ_OFS_IRQ_MASK 8'h1c
// control register fields
`define IBTQ_CTL_METHOD_LSB 0
`define IBTQ_CTL_METHOD_MSB 1
`define IBTQ_CTL_OPMODE_BIT 4
`define IBTQ_CTL_POLICY_LSB 8
`define IBTQ_CTL_POLICY_MSB 9
`define IBTQ_CTL_CLOSE_BIT 12
// control method encodings
`define IBTQ_METHOD_BASIC 2'h0
`define IBTQ_METHOD_AUTO 2'h1
`define IBTQ_METHOD_USER 2'h2
// operating mode encodings
`define IBTQ_OPMODE_CONT 1'h0
`define IBTQ_OPMODE_MULTI 1'h1
// queue policy encoding
`define IBTQ_POLICY_OLDEST_FIRST 2'h0
// command register bits
`define IBTQ_CMD_GO_BIT 0
`define IBTQ_CMD_HALT_BIT 1
// interrupt status bits
`define IBTQ_IRQ_DROP_BIT 0
`define IBTQ_IRQ_SENT_BIT 1
`define IBTQ_IRQ_DONE_BIT 2
// queue geometry
`define IBTQ_DEPTH 4
`define IBTQ_AW 2
`define IBTQ_CW 3
`define IBTQ_BLKW 16
`define IBTQ_PKT_WORDS 16'h0004
// reset values
`define IBTQ_RST_BLOCKS 32'h00000001
`endif

//--- ibtq_axil_slave.v
// axi4-lite register slave for the transfer queue
`default_nettype none
`include "ibtq_consts.vh"
module ibtq_axil_slave (
	// clock, reset, enable
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// axi write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// register side
	output reg wr_pulse,
	output reg [7:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	output wire [7:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_hit
);
	reg aw_have_reg;
	reg w_have_reg;
	reg [7:0] araddr_reg;
	reg rd_pend_reg;
	assign rd_addr = araddr_reg;
	// ************************************
	// write path
	// ************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			wr_pulse <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else if (ce) begin
			wr_pulse <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				w_have_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
				wr_pulse <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr <= `IBTQ_OFS_IRQ_MASK && wr_addr[1:0] == 2'h0) ?
					2'h0 : 2'h2;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// ************************************
	// read path
	// ************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			araddr_reg <= 8'h00;
			rd_pend_reg <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				araddr_reg <= s_axi_araddr;
				s_axi_arready <= 1'b0;
				rd_pend_reg <= 1'b1;
			end
			if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_hit ? rd_data : 32'h00000000;
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // ibtq_axil_slave
`default_nettype wire

//--- ibtq_block_store.v
// queue slot storage: block length per slot
`default_nettype none
`include "ibtq_consts.vh"
module ibtq_block_store (
	// clock, reset, enable
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// write port
	input wire wr_en,
	input wire [`IBTQ_AW-1:0] wr_idx,
	input wire [`IBTQ_BLKW-1:0] wr_len,
	// read port
	input wire [`IBTQ_AW-1:0] rd_idx,
	output wire [`IBTQ_BLKW-1:0] rd_len
);
	reg [`IBTQ_BLKW-1:0] mem_reg [0:`IBTQ_DEPTH-1];
	integer i;
	assign rd_len = mem_reg[rd_idx];
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < `IBTQ_DEPTH; i = i + 1) begin
				mem_reg[i] <= {`IBTQ_BLKW{1'b0}};
			end
		end else if (ce && wr_en) begin
			mem_reg[wr_idx] <= wr_len;
		end
	end
endmodule // ibtq_block_store
`default_nettype wire

//--- ibtq_top.v
// image block transfer queue: top level
// Function
// - basic/automatic: start sending once one packet's worth of block is buffered
// - user-controlled method: transmission governed by host commands only
// - user continuous: send back to back while go/halt gate streaming
// - multi block: after go, send the programmed count (one block if the count is 0), then stop
// - host-writable block count holds number of blocks to stream
// - block count only matters in multi-block mode
// - read-only queue capacity in blocks
// - read-only occupancy equals blocks held in the queue
// - read-only count of blocks dropped before transmission
// - host-writable queue policy; oldest-first is the only value
// - write-only go command starts streaming; the command offset reads back the streaming state in bit 0
// - write-only halt command stops streaming
// - halt lets the block in progress finish
// - go and halt act only in user-controlled method
// - full queue: new block overwrites oldest unsent block, drop count +1
// - oldest block is always sent next; an overwrite while the head is in flight puts the new block at head+1 next
// - acquisition never disturbs queue; closing the stream clears it
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`default_nettype none
`include "ibtq_consts.vh"
module ibtq_top (
	// clock, reset, enable
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// axi write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// finished blocks from acquisition path
	input wire blk_done,
	input wire [15:0] blk_len,
	input wire blk_word,
	// stream channel words out
	output reg tx_word,
	output reg tx_first,
	output reg tx_last,
	input wire tx_ready,
	// interrupt
	output reg irq
);
	// ************************************
	// registers
	// ************************************
	reg [1:0] xfer_control_method;
	reg xfer_operating_mode;
	reg [1:0] queue_policy;
	reg stream_close_reg;
	reg [31:0] blocks_to_send;
	reg [`IBTQ_CW-1:0] queue_occupancy;
	reg [31:0] queue_drop_count;
	reg [2:0] irq_status_reg;
	reg [2:0] irq_mask_reg;
	reg [`IBTQ_AW-1:0] head_reg;
	reg [`IBTQ_AW-1:0] tail_reg;
	reg streaming_reg;
	reg [31:0] sent_count_reg;
	reg [15:0] fill_words_reg;
	reg [15:0] tx_left_reg;
	reg live_reg;
	reg cut_reg;
	reg [15:0] live_sent_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	localparam S_IDLE = 2'h0;
	localparam S_SEND = 2'h1;
	wire wr_pulse;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [7:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_hit;
	wire [`IBTQ_BLKW-1:0] head_len;
	wire [31:0] depth_word = `IBTQ_DEPTH;
	wire [`IBTQ_CW-1:0] capacity = depth_word[`IBTQ_CW-1:0];
	// ************************************
	// bus slave and slot storage
	// ************************************
	ibtq_axil_slave u_bus (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_strb(wr_strb), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit)
	);
	wire full = (queue_occupancy == capacity);
	wire empty = (queue_occupancy == {`IBTQ_CW{1'b0}});
	wire sending = (state_reg == S_SEND);
	// slot being filled is the tail; head slot is locked while being sent
	wire head_locked = sending && !cut_reg;
	// a block already going out cut-through does not enter the queue
	wire arrive = blk_done && !live_reg;
	// overwrite oldest unsent: head if idle, head+1 if head is in flight
	wire [`IBTQ_AW-1:0] victim = head_locked ? head_reg + 1'b1 : head_reg;
	wire can_drop = full && !(head_locked && queue_occupancy == 3'h1);
	wire wr_fire = arrive && (!full || can_drop);
	wire [`IBTQ_AW-1:0] wr_slot = full ? victim : tail_reg;
	ibtq_block_store u_store (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.wr_en(wr_fire), .wr_idx(wr_slot), .wr_len(blk_len),
		.rd_idx(head_reg), .rd_len(head_len)
	);
	// ************************************
	// register writes
	// ************************************
	wire wr_ctl = wr_pulse && wr_addr == `IBTQ_OFS_CONTROL && wr_strb[0];
	wire wr_cmd = wr_pulse && wr_addr == `IBTQ_OFS_COMMAND && wr_strb[0];
	wire is_user = (xfer_control_method == `IBTQ_METHOD_USER);
	wire go_cmd = wr_cmd && wr_data[`IBTQ_CMD_GO_BIT] && is_user;
	wire halt_cmd = wr_cmd && wr_data[`IBTQ_CMD_HALT_BIT] && is_user;
	wire multi = is_user && xfer_operating_mode == `IBTQ_OPMODE_MULTI;
	// while a block is still arriving, one word is held back until its length is known
	wire word_ok = !live_reg || (live_sent_reg + 16'h0001 < fill_words_reg);
	wire send_now = sending && tx_ready && word_ok;
	wire blk_end = send_now && !live_reg && tx_left_reg == 16'h0001;
	wire close_now = stream_close_reg;
	always @(posedge aclk) begin
		if (!aresetn) begin
			xfer_control_method <= `IBTQ_METHOD_BASIC;
			xfer_operating_mode <= `IBTQ_OPMODE_CONT;
			queue_policy <= `IBTQ_POLICY_OLDEST_FIRST;
			stream_close_reg <= 1'b0;
			blocks_to_send <= `IBTQ_RST_BLOCKS;
			irq_mask_reg <= 3'h0;
		end else if (ce) begin
			if (wr_ctl) begin
				xfer_control_method <= wr_data[`IBTQ_CTL_METHOD_MSB:`IBTQ_CTL_METHOD_LSB];
				if (wr_strb[1]) begin
					// only oldest-first is accepted; others keep the old value
					if (wr_data[`IBTQ_CTL_POLICY_MSB:`IBTQ_CTL_POLICY_LSB] ==
						`IBTQ_POLICY_OLDEST_FIRST) begin
						queue_policy <= `IBTQ_POLICY_OLDEST_FIRST;
					end
					stream_close_reg <= wr_data[`IBTQ_CTL_CLOSE_BIT];
				end
				xfer_operating_mode <= wr_data[`IBTQ_CTL_OPMODE_BIT];
			end
			if (wr_pulse && wr_addr == `IBTQ_OFS_BLOCKS && wr_strb == 4'hf) begin
				blocks_to_send <= wr_data;
			end
			if (wr_pulse && wr_addr == `IBTQ_OFS_IRQ_MASK && wr_strb[0]) begin
				irq_mask_reg <= wr_data[2:0];
			end
		end
	end
	// ************************************
	// queue, streaming gate and sender
	// ************************************
	// basic/auto: always streaming; user: gated by go/halt
	wire gate_open = is_user ? streaming_reg : 1'b1;
	// cut-through: head may start once a packet is buffered or block complete
	wire head_ready = !empty && !close_now && gate_open;
	wire pkt_ready = (fill_words_reg >= `IBTQ_PKT_WORDS);
	wire cut_start = (state_reg == S_IDLE) && empty && pkt_ready && gate_open && !close_now
		&& !blk_done;
	wire start_tx = ((state_reg == S_IDLE) && head_ready) || cut_start;
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (start_tx) begin
					state_next = S_SEND;
				end
			end
			S_SEND: begin
				if (blk_end) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= S_IDLE;
			head_reg <= {`IBTQ_AW{1'b0}};
			tail_reg <= {`IBTQ_AW{1'b0}};
			queue_occupancy <= {`IBTQ_CW{1'b0}};
			queue_drop_count <= 32'h00000000;
			streaming_reg <= 1'b0;
			sent_count_reg <= 32'h00000000;
			fill_words_reg <= 16'h0000;
			tx_left_reg <= 16'h0000;
			live_reg <= 1'b0;
			cut_reg <= 1'b0;
			live_sent_reg <= 16'h0000;
			tx_word <= 1'b0;
			tx_first <= 1'b0;
			tx_last <= 1'b0;
			irq_status_reg <= 3'h0;
			irq <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			tx_word <= 1'b0;
			tx_first <= 1'b0;
			tx_last <= 1'b0;
			// words of the block being acquired, for cut-through start
			fill_words_reg <= blk_done ? 16'h0000 : fill_words_reg + {15'h0000, blk_word};
			if (close_now) begin
				// closing the stream drops queue and pending sends
				head_reg <= {`IBTQ_AW{1'b0}};
				tail_reg <= {`IBTQ_AW{1'b0}};
				queue_occupancy <= {`IBTQ_CW{1'b0}};
				streaming_reg <= 1'b0;
				if (!sending) begin
					state_reg <= S_IDLE;
				end
			end else begin
				if (wr_fire && !full) begin
					tail_reg <= tail_reg + 1'b1;
				end
				if (arrive && full && can_drop) begin
					queue_drop_count <= queue_drop_count + 32'h00000001;
				end
				if (blk_end && !cut_reg) begin
					head_reg <= head_reg + 1'b1;
				end
				// full and head not in flight: oldest overwritten in place, ring turns by one
				if (arrive && full && can_drop && !head_locked) begin
					head_reg <= head_reg + 1'b1;
					tail_reg <= tail_reg + 1'b1;
				end
				// occupancy bounded by capacity via full check
				case ({wr_fire && !full, blk_end && !cut_reg})
					2'b10: queue_occupancy <= queue_occupancy + 1'b1;
					2'b01: queue_occupancy <= queue_occupancy - 1'b1;
					default: queue_occupancy <= queue_occupancy;
				endcase
				if (go_cmd) begin
					streaming_reg <= 1'b1;
					sent_count_reg <= 32'h00000000;
				end else if (halt_cmd) begin
					streaming_reg <= 1'b0;
				end else if (blk_end && multi) begin
					sent_count_reg <= sent_count_reg + 32'h00000001;
					if (sent_count_reg + 32'h00000001 >= blocks_to_send) begin
						streaming_reg <= 1'b0;
					end
				end
			end
			if (start_tx) begin
				tx_left_reg <= head_len;
				tx_first <= 1'b1;
				live_reg <= cut_start;
				cut_reg <= cut_start;
				live_sent_reg <= 16'h0000;
			end
			if (send_now) begin
				tx_word <= 1'b1;
				tx_last <= !live_reg && (tx_left_reg == 16'h0001);
				tx_left_reg <= tx_left_reg - 16'h0001;
				live_sent_reg <= live_sent_reg + 16'h0001;
			end
			// length known at last: what is left after this cycle's word
			if (live_reg && blk_done) begin
				live_reg <= 1'b0;
				tx_left_reg <= blk_len - live_sent_reg - {15'h0000, send_now};
			end
			// sticky events: set wins over write-one-to-clear
			irq_status_reg <= (irq_status_reg &
				~((wr_pulse && wr_addr == `IBTQ_OFS_IRQ_STATUS) ? wr_data[2:0] : 3'h0))
				| {(blk_end && multi && sent_count_reg + 32'h00000001 >= blocks_to_send),
				blk_end, (arrive && full && can_drop)};
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end
	// ************************************
	// register reads
	// ************************************
	always @* begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		case (rd_addr)
			`IBTQ_OFS_CONTROL: rd_data = {19'h00000, stream_close_reg, 2'h0, queue_policy,
				3'h0, xfer_operating_mode, 2'h0, xfer_control_method};
			`IBTQ_OFS_BLOCKS: rd_data = blocks_to_send;
			`IBTQ_OFS_COMMAND: rd_data = {31'h00000000, streaming_reg};
			`IBTQ_OFS_CAPACITY: rd_data = {29'h00000000, capacity};
			`IBTQ_OFS_OCCUPANCY: rd_data = {29'h00000000, queue_occupancy};
			`IBTQ_OFS_DROPS: rd_data = queue_drop_count;
			`IBTQ_OFS_IRQ_STATUS: rd_data = {29'h00000000, irq_status_reg};
			`IBTQ_OFS_IRQ_MASK: rd_data = {29'h00000000, irq_mask_reg};
			default: rd_hit = 1'b0;
		endcase
	end
endmodule // ibtq_top
`default_nettype wire

//--- ibtq_properties.sv
// checker: port-level properties of the transfer queue
`default_nettype none
module ibtq_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// stream words
	input wire logic tx_word,
	input wire logic tx_first,
	input wire logic tx_last,
	input wire logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***************
	// block tracking
	// ***************
	logic inb_reg;
	always @(posedge aclk) begin
		if (!aresetn)
			inb_reg <= 1'b0;
		else if (tx_first)
			inb_reg <= 1'b1;
		else if (tx_last)
			inb_reg <= 1'b0;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_word_needs_ready: assert property (tx_word |-> $past(tx_ready))
		else $error("word sent without ready");
	a_last_is_word: assert property (tx_last |-> tx_word)
		else $error("last pulse without word");
	a_block_not_cut: assert property (tx_first |-> !inb_reg && !tx_word)
		else $error("new block before last word");
	a_word_in_block: assert property (tx_word |-> inb_reg)
		else $error("word outside a block");
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (s_rd_taken |-> ##[1:3] s_axi_rvalid)
		else $error("read not answered");
	a_bresp_holds: assert property (s_axi_bvalid |=> ($past(s_axi_bready) ? !s_axi_bvalid
		: (s_axi_bvalid && $stable(s_axi_bresp))))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid |=> ($past(s_axi_rready) ? !s_axi_rvalid
		: (s_axi_rvalid && $stable(s_axi_rdata))))
		else $error("read data dropped");
	a_ready_idle: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken before response");
endmodule // ibtq_properties
`default_nettype wire

//--- ibtq_rx_model.sv
// stream receiver model: ready pattern, block framing and lengths
`default_nettype none
module ibtq_rx_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// stream words
	input wire logic tx_word,
	input wire logic tx_first,
	input wire logic tx_last,
	output logic tx_ready,
	// stall select
	input wire logic slow
);
	timeunit 1ns;
	timeprecision 1ps;
	int nblk, cnt, lens[64];
	logic busy, ph;
	// slow receiver accepts every other cycle
	assign tx_ready = !slow || ph;
	always @(posedge aclk) begin
		if (!aresetn) begin
			nblk <= 0;
			busy <= 1'b0;
			ph <= 1'b0;
		end else begin
			ph <= ~ph;
			if (tx_first) begin
				busy <= 1'b1;
				cnt <= 0;
			end
			if (tx_word && tx_last) begin
				lens[nblk] <= cnt + 1;
				nblk <= nblk + 1;
				busy <= 1'b0;
			end else if (tx_word)
				cnt <= cnt + 1;
		end
	end
endmodule // ibtq_rx_model
`default_nettype wire

//--- tb_image_block_transfer_queue.sv
// testbench for the image block transfer queue
`default_nettype none
module tb_image_block_transfer_queue;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, blk_done, blk_word, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [15:0] blk_len;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic tx_word, tx_first, tx_last, tx_ready, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
	int fail_count, n_checks;
	ibtq_top dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .blk_done, .blk_len, .blk_word,
		.tx_word, .tx_first, .tx_last, .tx_ready, .irq);
	ibtq_rx_model rx_u (.aclk, .aresetn, .tx_word, .tx_first, .tx_last, .tx_ready, .slow);
	// ***************
	// bus, block and check tasks
	// ***************
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		bresp_q = s_axi_bresp;
		if (n == 50) fail_count++;
	endtask
	task automatic rc(input string w, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rresp_q = s_axi_rresp;
		if (n == 50) fail_count++;
		chk(w, e, s_axi_rdata & m);
	endtask
	task automatic push(input int len);
		repeat (len) begin
			blk_word <= 1'b1;
			@(posedge aclk);
		end
		blk_word <= 1'b0;
		blk_len <= len[15:0];
		blk_done <= 1'b1;
		@(posedge aclk);
		blk_done <= 1'b0;
	endtask
	task automatic wait_blk(input int n);
		int k;
		for (k = 0; k < 400 && rx_u.nblk < n; k++) @(posedge aclk);
		if (k == 400) fail_count++;
	endtask
	// ***************
	// scenarios
	// ***************
	task automatic t_regs;
		rc("capacity", 8'h0c, 32'h00000004);
		rc("occupancy", 8'h10, 32'h00000000);
		rc("drops", 8'h14, 32'h00000000);
		rc("blocks", 8'h04, 32'h00000001);
		rc("unmapped", 8'h40, 32'h00000000);
		chk("unmapped resp", 32'h00000002, {30'h0, rresp_q});
		axw(8'h0c, 32'h0000000f);
		chk("capacity wresp", 32'h00000000, {30'h0, bresp_q});
		rc("capacity", 8'h0c, 32'h00000004);
		axw(8'h40, 32'h00000000);
		chk("unmapped wresp", 32'h00000002, {30'h0, bresp_q});
		$display("test regs done");
	endtask
	task automatic t_multi;
		int b;
		b = rx_u.nblk;
		axw(8'h00, 32'h00000012);
		axw(8'h04, 32'h00000002);
		push(2);
		push(3);
		push(4);
		repeat (20) @(posedge aclk);
		chk("held by user", b, rx_u.nblk);
		rc("occupancy", 8'h10, 32'h00000003);
		rc("blocks", 8'h04, 32'h00000002);
		axw(8'h1c, 32'h00000004);
		axw(8'h08, 32'h00000001);
		wait_blk(b + 2);
		repeat (40) @(posedge aclk);
		chk("multi count", b + 2, rx_u.nblk);
		chk("first len", 2, rx_u.lens[b]);
		chk("second len", 3, rx_u.lens[b + 1]);
		rc("occupancy", 8'h10, 32'h00000001);
		chk("irq done", 1, irq);
		rc("done status", 8'h18, 32'h00000004, 32'h00000004);
		axw(8'h18, 32'h00000007);
		repeat (3) @(posedge aclk);
		chk("irq cleared", 0, irq);
		axw(8'h1c, 32'h00000000);
		$display("test multi done");
	endtask
	task automatic t_halt;
		int b, k;
		b = rx_u.nblk;
		axw(8'h00, 32'h00000002);
		axw(8'h04, 32'h00000001);
		axw(8'h08, 32'h00000001);
		wait_blk(b + 1);
		slow <= 1'b1;
		push(8);
		for (k = 0; k < 200 && !rx_u.busy && rx_u.nblk < b + 2; k++) @(posedge aclk);
		axw(8'h08, 32'h00000002);
		wait_blk(b + 2);
		chk("whole block", 8, rx_u.lens[b + 1]);
		push(2);
		repeat (40) @(posedge aclk);
		chk("halted", b + 2, rx_u.nblk);
		rc("stream state", 8'h08, 32'h00000000, 32'h00000001);
		slow <= 1'b0;
		$display("test halt done");
	endtask
	task automatic t_auto;
		int b;
		b = rx_u.nblk;
		axw(8'h00, 32'h00000000);
		axw(8'h08, 32'h00000002);
		axw(8'h08, 32'h00000001);
		rc("go ignored", 8'h08, 32'h00000000, 32'h00000001);
		wait_blk(b + 1);
		push(3);
		wait_blk(b + 2);
		axw(8'h00, 32'h00000001);
		push(5);
		@(posedge aclk);
		chk("cut through", 1, rx_u.busy);
		wait_blk(b + 3);
		chk("basic len", 2, rx_u.lens[b]);
		chk("auto len", 5, rx_u.lens[b + 2]);
		$display("test auto done");
	endtask
	task automatic t_over;
		int b;
		axw(8'h00, 32'h00000002);
		axw(8'h08, 32'h00000002);
		b = rx_u.nblk;
		repeat (6) push(1);
		repeat (5) @(posedge aclk);
		chk("no send", b, rx_u.nblk);
		rc("occupancy", 8'h10, 32'h00000004);
		rc("drops", 8'h14, 32'h00000002);
		chk("irq masked", 0, irq);
		axw(8'h1c, 32'h00000001);
		repeat (3) @(posedge aclk);
		chk("irq drop", 1, irq);
		axw(8'h18, 32'h00000001);
		repeat (3) @(posedge aclk);
		chk("irq cleared", 0, irq);
		axw(8'h00, 32'h00001002);
		repeat (3) @(posedge aclk);
		axw(8'h00, 32'h00000002);
		rc("closed", 8'h10, 32'h00000000);
		axw(8'h00, 32'h00000102);
		rc("policy", 8'h00, 32'h00000000, 32'h00000300);
		$display("test over done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial begin
		#400000;
		fail_count++;
		finish_test;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{blk_done, blk_word, slow, s_axi_awaddr, s_axi_araddr} = '0;
		// responses are taken as soon as they stand
		{s_axi_bready, s_axi_rready} = 2'b11;
		{s_axi_wdata, blk_len} = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_multi;
		t_halt;
		t_auto;
		t_over;
		finish_test;
	end
endmodule // tb_image_block_transfer_queue
bind ibtq_top ibtq_properties chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_word, .tx_first,
	.tx_last, .tx_ready);
`default_nettype wire
